/* File: core/qc_counter.sv */
`timescale 1ns/10ps
// How it works
// - each rising and each falling edge of the pulse input is one count step.
// - count steps only take effect while the enable bit is set.
// - with the direction bit set steps decrement, otherwise they increment.
// - load coil replaces the value with the preset; flags follow at once.
// - after a load in run mode, counting continues normally from the preset value.
// - clear coil forces the value to zero, which raises the zero flag.
// - clear coil acts only while run mode is set; ignored in stop.
// - outside overrun, upper flag is high exactly when value is at or above upper setpoint.
// - outside overrun, lower flag is high exactly when value is at or below lower setpoint.
// - zero flag is high exactly when the value equals zero.
// - a step past the 32-bit range sets range flag; limit flags show direction.
// - the current value is always presented as signed integer on the output.
// - retentive counter keeps its value across run-to-stop and reset.
// - retentive counter resumes from saved value when run starts, else from zero.
// - value, setpoints and preset are full signed 32-bit quantities.
// - while range flag is set the last valid value is held.
// - the preset is taken on the rising edge of the load coil.
module qc_counter
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire qc_pkg::qc_ahb_req_s ahb_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic count_pulse_i,
   input wire logic retain_i,
   output logic signed [31:0] actual_count_out_o,
   output logic upper_limit_flag_o,
   output logic lower_limit_flag_o,
   output logic zero_flag_o,
   output logic range_exceeded_flag_o
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   qc_pkg::qc_state_e state;
   logic [4:0] ctrl;
   logic signed [31:0] upper_setpoint;
   logic signed [31:0] lower_setpoint;
   logic signed [31:0] preset_value;
   logic signed [31:0] value;
   logic signed [31:0] next_value;
   logic range_exceeded;
   logic next_range_exceeded;
   logic overrun_up;
   logic next_overrun_up;
   logic retentive;
   logic pulse_q;
   logic load_q;
   logic run_q;
   logic wr_pend;
   logic [7:0] wr_addr;
   qc_pkg::qc_flags_s flags;
   qc_pkg::qc_flags_s next_flags;
   logic addr_phase;
   logic pulse_edge;
   logic load_rise;
   logic run_start;
   logic clear_now;
   logic step_now;
   logic signed [32:0] step_sum;
   logic step_ovf;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic signed [32:0] step_value(input logic signed [31:0] v, input logic down);
      logic signed [32:0] wide;
      wide = {v[31], v};
      if (down)
      begin
         step_value = wide - {qc_pkg::VALUE_ONE[31], qc_pkg::VALUE_ONE};
      end
      else
      begin
         step_value = wide + {qc_pkg::VALUE_ONE[31], qc_pkg::VALUE_ONE};
      end
   endfunction

   function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [4:0] c,
                                            input logic signed [31:0] up, input logic signed [31:0] lo,
                                            input logic signed [31:0] pv, input logic signed [31:0] v,
                                            input qc_pkg::qc_flags_s f, input logic ret);
      logic [31:0] r;
      r = 32'h00000000;
      case (a)
         qc_pkg::ADDR_CTRL: r[qc_pkg::CTRL_W-1:0] = c;
         qc_pkg::ADDR_UPPER: r = up;
         qc_pkg::ADDR_LOWER: r = lo;
         qc_pkg::ADDR_PRESET: r = pv;
         qc_pkg::ADDR_COUNT: r = v;
         qc_pkg::ADDR_STATUS:
         begin
            r[qc_pkg::STAT_UPPER] = f.upper_limit_flag;
            r[qc_pkg::STAT_LOWER] = f.lower_limit_flag;
            r[qc_pkg::STAT_ZERO] = f.zero_flag;
            r[qc_pkg::STAT_RANGE] = f.range_exceeded_flag;
            r[qc_pkg::STAT_RETAIN] = ret;
         end
         default: r = 32'h00000000;
      endcase
      read_mux = r;
   endfunction

   // ***************************************************************
   // AHB-Lite slave
   // ***************************************************************
   assign addr_phase = ahb_i.hsel && ahb_i.hready &&
                       (ahb_i.htrans == qc_pkg::HTRANS_NONSEQ || ahb_i.htrans == qc_pkg::HTRANS_SEQ);

   // zero wait states, always OKAY
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hreadyout_o <= 1'h1;
         hresp_o <= qc_pkg::HRESP_OKAY;
      end
      else
      begin
         hreadyout_o <= 1'h1;
         hresp_o <= qc_pkg::HRESP_OKAY;
      end
   end

   // write address is held for the data phase
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_pend <= 1'h0;
         wr_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= addr_phase && ahb_i.hwrite;
         wr_addr <= ahb_i.haddr[7:0];
      end
   end

   // read data is captured in the address phase
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         hrdata_o <= 32'h00000000;
      end
      else if (addr_phase && !ahb_i.hwrite)
      begin
         hrdata_o <= read_mux(ahb_i.haddr[7:0], ctrl, upper_setpoint, lower_setpoint,
                              preset_value, actual_count_out_o, flags, retentive);
      end
   end

   // ***************************************************************
   // software registers
   // ***************************************************************
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl <= qc_pkg::CTRL_RESET;
         upper_setpoint <= qc_pkg::VALUE_ZERO;
         lower_setpoint <= qc_pkg::VALUE_ZERO;
         preset_value <= qc_pkg::VALUE_ZERO;
      end
      else if (wr_pend)
      begin
         // setpoints and preset are full signed 32-bit words, no range limiting; ctrl keeps only its low CTRL_W bits
         case (wr_addr)
            qc_pkg::ADDR_CTRL: ctrl <= hwdata_i[qc_pkg::CTRL_W-1:0];
            qc_pkg::ADDR_UPPER: upper_setpoint <= hwdata_i;
            qc_pkg::ADDR_LOWER: lower_setpoint <= hwdata_i;
            qc_pkg::ADDR_PRESET: preset_value <= hwdata_i;
            default: ctrl <= ctrl;
         endcase
      end
   end

   // ***************************************************************
   // power-up sequence and retention strap
   // ***************************************************************
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state <= qc_pkg::ST_POWERUP;
         retentive <= 1'h0;
      end
      else
      begin
         case (state)
            qc_pkg::ST_POWERUP:
            begin
               retentive <= retain_i;
               state <= qc_pkg::ST_ACTIVE;
            end
            qc_pkg::ST_ACTIVE: state <= qc_pkg::ST_ACTIVE;
            default: state <= qc_pkg::ST_POWERUP;
         endcase
      end
   end

   // ***************************************************************
   // edge detection on pulse input and coils
   // ***************************************************************
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pulse_q <= 1'h0;
         load_q <= 1'h0;
         run_q <= 1'h0;
      end
      else
      begin
         pulse_q <= count_pulse_i;
         load_q <= ctrl[qc_pkg::CTRL_LOAD];
         run_q <= ctrl[qc_pkg::CTRL_RUN];
      end
   end

   assign pulse_edge = (state == qc_pkg::ST_ACTIVE) && (count_pulse_i != pulse_q);
   assign load_rise = ctrl[qc_pkg::CTRL_LOAD] && !load_q;
   assign run_start = ctrl[qc_pkg::CTRL_RUN] && !run_q;
   assign clear_now = ctrl[qc_pkg::CTRL_CLEAR] && ctrl[qc_pkg::CTRL_RUN];
   assign step_now = pulse_edge && ctrl[qc_pkg::CTRL_ENABLE] && ctrl[qc_pkg::CTRL_RUN];
   assign step_sum = step_value(value, ctrl[qc_pkg::CTRL_DOWN]);
   assign step_ovf = step_sum[32] != step_sum[31];

   // ***************************************************************
   // next value
   // ***************************************************************
   always_comb
   begin
      next_value = value;
      next_range_exceeded = range_exceeded;
      next_overrun_up = overrun_up;
      if (state == qc_pkg::ST_POWERUP)
      begin
         // a retentive counter keeps the stored word over reset
         if (!retain_i)
         begin
            next_value = qc_pkg::VALUE_ZERO;
         end
         next_range_exceeded = 1'h0;
         next_overrun_up = 1'h0;
      end
      else if (clear_now)
      begin
         next_value = qc_pkg::VALUE_ZERO;
         next_range_exceeded = 1'h0;
      end
      else if (load_rise)
      begin
         next_value = preset_value;
         next_range_exceeded = 1'h0;
      end
      else if (run_start && !retentive)
      begin
         next_value = qc_pkg::VALUE_ZERO;
         next_range_exceeded = 1'h0;
      end
      else if (range_exceeded)
      begin
         next_value = value;
      end
      else if (step_now)
      begin
         if (step_ovf)
         begin
            next_range_exceeded = 1'h1;
            next_overrun_up = !ctrl[qc_pkg::CTRL_DOWN];
         end
         else
         begin
            next_value = step_sum[31:0];
         end
      end
   end

   // ***************************************************************
   // value storage, no reset so the word survives it
   // ***************************************************************
   always_ff @(posedge clk_i)
   begin
      value <= next_value;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         range_exceeded <= 1'h0;
         overrun_up <= 1'h0;
      end
      else
      begin
         range_exceeded <= next_range_exceeded;
         overrun_up <= next_overrun_up;
      end
   end

   // ***************************************************************
   // flags, computed from the next value so they move with it
   // ***************************************************************
   qc_cmp u_cmp
   (
      .value_i(next_value),
      .upper_setpoint_i(upper_setpoint),
      .lower_setpoint_i(lower_setpoint),
      .range_exceeded_i(next_range_exceeded),
      .overrun_up_i(next_overrun_up),
      .flags_o(next_flags)
   );

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         flags <= '0;
      end
      else
      begin
         flags <= next_flags;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         actual_count_out_o <= qc_pkg::VALUE_ZERO;
      end
      else
      begin
         actual_count_out_o <= next_value;
      end
   end

   assign upper_limit_flag_o = flags.upper_limit_flag;
   assign lower_limit_flag_o = flags.lower_limit_flag;
   assign zero_flag_o = flags.zero_flag;
   assign range_exceeded_flag_o = flags.range_exceeded_flag;

endmodule

/* File: common/qc_pkg.sv */
package qc_pkg;

   // ***************************************************************
   // widths and value range
   // ***************************************************************
   localparam int VALUE_W = 32;
   localparam logic signed [31:0] VALUE_MAX = 32'sh7FFFFFFF;
   localparam logic signed [31:0] VALUE_MIN = 32'sh80000000;
   localparam logic signed [31:0] VALUE_ZERO = 32'sh00000000;
   localparam logic signed [31:0] VALUE_ONE = 32'sh00000001;

   // highest pulse rate the source may deliver, in hertz
   localparam int PULSE_MAX_HZ = 3000;

   // ***************************************************************
   // register map, byte addresses
   // ***************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_UPPER = 8'h04;
   localparam logic [7:0] ADDR_LOWER = 8'h08;
   localparam logic [7:0] ADDR_PRESET = 8'h0C;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // control register fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_DOWN = 1;
   localparam int CTRL_LOAD = 2;
   localparam int CTRL_CLEAR = 3;
   localparam int CTRL_RUN = 4;
   localparam int CTRL_W = 5;
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // status register fields
   localparam int STAT_UPPER = 0;
   localparam int STAT_LOWER = 1;
   localparam int STAT_ZERO = 2;
   localparam int STAT_RANGE = 3;
   localparam int STAT_RETAIN = 4;

   // ***************************************************************
   // AHB-Lite encodings
   // ***************************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'h0;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } qc_ahb_req_s;

   typedef struct packed {
      logic upper_limit_flag;
      logic lower_limit_flag;
      logic zero_flag;
      logic range_exceeded_flag;
   } qc_flags_s;

   typedef enum logic [0:0] {
      ST_POWERUP,
      ST_ACTIVE
   } qc_state_e;

endpackage

/* File: core/qc_cmp.sv */
`timescale 1ns/10ps
module qc_cmp
(
   input wire logic signed [31:0] value_i,
   input wire logic signed [31:0] upper_setpoint_i,
   input wire logic signed [31:0] lower_setpoint_i,
   input wire logic range_exceeded_i,
   input wire logic overrun_up_i,
   output qc_pkg::qc_flags_s flags_o
);

   // ***************************************************************
   // setpoint and zero comparison
   // ***************************************************************
   always_comb
   begin
      flags_o.zero_flag = (value_i == qc_pkg::VALUE_ZERO);
      flags_o.range_exceeded_flag = range_exceeded_i;
      if (range_exceeded_i)
      begin
         // overrun direction decides which limit contact closes
         flags_o.upper_limit_flag = overrun_up_i;
         flags_o.lower_limit_flag = !overrun_up_i;
      end
      else
      begin
         flags_o.upper_limit_flag = (value_i >= upper_setpoint_i);
         flags_o.lower_limit_flag = (value_i <= lower_setpoint_i);
      end
   end

endmodule

/* File: testbench/qc_counter_assertions.sv */
`timescale 1ns/10ps
// ********
// counter checker
// ********
module qc_chk
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire qc_pkg::qc_ahb_req_s ahb_i,
   input wire logic [31:0] hrdata_o,
   input wire logic count_pulse_i,
   input wire logic signed [31:0] actual_count_out_o,
   input wire logic upper_limit_flag_o,
   input wire logic lower_limit_flag_o,
   input wire logic zero_flag_o,
   input wire logic range_exceeded_flag_o
);
   logic [1:0] up;
   logic ok;
   logic wr_ph;
   logic rd_cnt;
   assign ok = (up == 2'h3);
   assign wr_ph = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1] & ahb_i.hwrite;
   assign rd_cnt = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1] & !ahb_i.hwrite
      & (ahb_i.haddr[7:0] == qc_pkg::ADDR_COUNT);
   // history is trusted only once the power-up step is behind us
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         up <= 2'h0;
      else if (!ok)
         up <= up + 2'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_zero_match: assert property (ok |-> zero_flag_o == (actual_count_out_o == 32'sh0))
      else $error("zero flag wrong");
   chk_change_cause: assert property (ok && $changed(actual_count_out_o) |->
      ($past(count_pulse_i) != $past(count_pulse_i, 2)) || $past(wr_ph, 3))
      else $error("count moved without cause");
   chk_step_unit: assert property (ok && $changed(actual_count_out_o) && !$past(wr_ph, 3) |->
      (actual_count_out_o - $past(actual_count_out_o) == 32'sh1)
      || ($past(actual_count_out_o) - actual_count_out_o == 32'sh1))
      else $error("step not one");
   chk_range_dirs: assert property (range_exceeded_flag_o |-> upper_limit_flag_o != lower_limit_flag_o)
      else $error("overrun direction wrong");
   chk_range_hold: assert property (range_exceeded_flag_o ##1 range_exceeded_flag_o |->
      $stable(actual_count_out_o))
      else $error("value moved in overrun");
   chk_range_release: assert property (ok && $fell(range_exceeded_flag_o) |-> $past(wr_ph, 3))
      else $error("overrun dropped alone");
   chk_flag_sync: assert property (ok && ($changed(upper_limit_flag_o) || $changed(lower_limit_flag_o)) |->
      $changed(actual_count_out_o) || $changed(range_exceeded_flag_o)
      || $past(wr_ph, 2) || $past(wr_ph, 3) || $past(wr_ph, 4))
      else $error("limit flag moved alone");
   chk_read_count: assert property (rd_cnt |=> hrdata_o == $past(actual_count_out_o))
      else $error("count read wrong");
   cover property ($rose(range_exceeded_flag_o));
   cover property ($rose(zero_flag_o));
   cover property (rd_cnt);
endmodule

bind qc_counter qc_chk u_chk
(
   .clk_i(clk_i),
   .rst_i(rst_i),
   .ahb_i(ahb_i),
   .hrdata_o(hrdata_o),
   .count_pulse_i(count_pulse_i),
   .actual_count_out_o(actual_count_out_o),
   .upper_limit_flag_o(upper_limit_flag_o),
   .lower_limit_flag_o(lower_limit_flag_o),
   .zero_flag_o(zero_flag_o),
   .range_exceeded_flag_o(range_exceeded_flag_o)
);

/* File: testbench/qc_pulse_src.sv */
`timescale 1ns/10ps
// ********
// pulse source
// ********
module qc_pulse_src
#(
   parameter int GAP = 3
)
(
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [7:0] edges_i,
   output logic pulse_o,
   output logic busy_o
);
   logic [7:0] left = 8'h0;
   int wait_n = 0;
   initial
      pulse_o = 1'b0;
   assign busy_o = (left != 8'h0);
   // edges spaced GAP+1 cycles apart, never faster than the counter takes them
   always @(posedge clk_i)
   begin
      if (start_i)
      begin
         left <= edges_i;
         wait_n <= GAP;
      end
      else if (left != 8'h0)
      begin
         if (wait_n == 0)
         begin
            pulse_o <= ~pulse_o;
            left <= left - 8'h1;
            wait_n <= GAP;
         end
         else
            wait_n <= wait_n - 1;
      end
   end
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
   // ********
   // signals and cases
   // ********
   typedef struct packed {
      logic [4:0] ctrl;
      logic [7:0] n;
      logic [31:0] c;
      logic [3:0] f;
   } qc_row_s;
   localparam qc_row_s ROWS [12] = '{
      '{5'h11, 8'h0, 32'h0, 4'h6}, '{5'h11, 8'h3, 32'h3, 4'h0},
      '{5'h11, 8'h2, 32'h5, 4'h1}, '{5'h10, 8'h4, 32'h5, 4'h1},
      '{5'h13, 8'h6, 32'hFFFFFFFF, 4'h2}, '{5'h17, 8'h0, 32'hFFFFFFFD, 4'h2},
      '{5'h11, 8'h4, 32'h1, 4'h2}, '{5'h19, 8'h2, 32'h0, 4'h6},
      '{5'h11, 8'h3, 32'h3, 4'h0}, '{5'h01, 8'h0, 32'h3, 4'h0},
      '{5'h09, 8'h2, 32'h3, 4'h0}, '{5'h11, 8'h0, 32'h0, 4'h6}};
   logic clk_i;
   logic rst_i;
   logic sel;
   logic wr;
   logic [1:0] trans;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic retain;
   logic start;
   logic [7:0] edges;
   logic pulse;
   logic busy;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic signed [31:0] cnt;
   logic [3:0] flags;
   logic [31:0] q;
   qc_pkg::qc_ahb_req_s bus;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   assign bus = {sel, addr, trans, wr, 3'h2, hready};
   qc_counter uut
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ahb_i(bus),
      .hwdata_i(wdata),
      .hrdata_o(hrdata),
      .hreadyout_o(hready),
      .hresp_o(hresp),
      .count_pulse_i(pulse),
      .retain_i(retain),
      .actual_count_out_o(cnt),
      .upper_limit_flag_o(flags[0]),
      .lower_limit_flag_o(flags[1]),
      .zero_flag_o(flags[2]),
      .range_exceeded_flag_o(flags[3])
   );
   qc_pulse_src src
   (
      .clk_i(clk_i),
      .start_i(start),
      .edges_i(edges),
      .pulse_o(pulse),
      .busy_o(busy)
   );
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count = bad_count + 1;
         give_verdict();
      end
   end
   // ********
   // tasks
   // ********
   task automatic give_verdict();
      if (bad_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      sel <= 1'b1;
      trans <= qc_pkg::HTRANS_NONSEQ;
      addr <= {24'h0, a};
      wr <= w;
      do @(posedge clk_i); while (hready !== 1'b1);
      sel <= 1'b0;
      trans <= 2'h0;
      wdata <= d;
      do @(posedge clk_i); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic send(input logic [7:0] n);
      start <= 1'b1;
      edges <= n;
      @(posedge clk_i);
      start <= 1'b0;
      repeat (2) @(posedge clk_i);
      while (busy !== 1'b0) @(posedge clk_i);
      repeat (3) @(posedge clk_i);
   endtask
   task automatic expect_state(input logic [31:0] c, input logic [3:0] f);
      cmp(cnt, c);
      cmp({28'h0, flags}, {28'h0, f});
      xfer(1'b0, qc_pkg::ADDR_COUNT, 32'h0);
      cmp(q, c);
      xfer(1'b0, qc_pkg::ADDR_STATUS, 32'h0);
      cmp(q & 32'hF, {28'h0, f});
   endtask
   task automatic ctrl(input logic [31:0] v);
      xfer(1'b1, qc_pkg::ADDR_CTRL, v);
   endtask
   // ********
   // sequence
   // ********
   initial
   begin
      rst_i = 1'b1;
      sel = 1'b0;
      wr = 1'b0;
      trans = 2'h0;
      addr = 32'h0;
      wdata = 32'h0;
      retain = 1'b0;
      start = 1'b0;
      edges = 8'h0;
      repeat (3) @(posedge clk_i);
      cmp(cnt, 32'h0);
      cmp({hresp, hready}, 32'h1);
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      xfer(1'b1, qc_pkg::ADDR_UPPER, 32'h5);
      xfer(1'b1, qc_pkg::ADDR_LOWER, 32'h1);
      xfer(1'b1, qc_pkg::ADDR_PRESET, 32'hFFFFFFFD);
      foreach (ROWS[i])
      begin
         ctrl({27'h0, ROWS[i].ctrl});
         send(ROWS[i].n);
         expect_state(ROWS[i].c, ROWS[i].f);
      end
      xfer(1'b1, qc_pkg::ADDR_PRESET, qc_pkg::VALUE_MAX - 32'sh1);
      ctrl(32'h15);
      send(8'h3);
      expect_state(qc_pkg::VALUE_MAX, 4'h9);
      ctrl(32'h13);
      send(8'h2);
      expect_state(qc_pkg::VALUE_MAX, 4'h9);
      ctrl(32'h19);
      send(8'h0);
      expect_state(32'h0, 4'h6);
      xfer(1'b1, qc_pkg::ADDR_PRESET, qc_pkg::VALUE_MIN + 32'sh1);
      ctrl(32'h17);
      send(8'h3);
      expect_state(qc_pkg::VALUE_MIN, 4'hA);
      xfer(1'b1, qc_pkg::ADDR_PRESET, 32'h7);
      ctrl(32'h13);
      ctrl(32'h15);
      send(8'h0);
      expect_state(32'h7, 4'h1);
      retain <= 1'b1;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      xfer(1'b1, qc_pkg::ADDR_UPPER, 32'h5);
      xfer(1'b1, qc_pkg::ADDR_LOWER, 32'h1);
      ctrl(32'h11);
      send(8'h2);
      expect_state(32'h9, 4'h1);
      cmp({31'h0, q[4]}, 32'h1);
      xfer(1'b1, qc_pkg::ADDR_COUNT, 32'h55);
      xfer(1'b1, 8'h20, 32'h55);
      xfer(1'b0, 8'h20, 32'h0);
      cmp(q, 32'h0);
      ctrl(32'hFFFFFFF1);
      xfer(1'b0, qc_pkg::ADDR_CTRL, 32'h0);
      cmp(q, 32'h11);
      expect_state(32'h9, 4'h1);
      give_verdict();
   end
endmodule
